// file: hw/host_global_cfg.sv
/*
  Global configuration, dual address base and group base registers on APB,
  applied to the expansion bus sequencer, host master address phase,
  target claim, interrupt pins and port to group mapping.
  Assumes all inputs are synchronous to clock_in and an external tristate.
*/
// Local design decisions: the register offsets and the APB interface to the registers.
// Overview of operation
// - Style 0: request/grant, address strobe, direction, read
// - Style 1: hold/ack, latch strobe, read and write strobes
// - Address held address stretch plus one periods
// - Data held data stretch plus one periods
// - Address strobe marks stretched setup elapsed
// - Data strobes mark stretched setup elapsed
// - Map 0: port n serves group n
// - Map 1: port n serves groups 2n, 2n+1
// - Map 2: port 0 groups 0-3, port 1 4-7
// - Zero upper base single cycle, else dual
// - Single cycle: address, command, one period
// - Dual cycle: dual command, then real command
// - Upper address word comes from upper base
// - Target never claims dual address cycles
// - Group pointer bits 31:11, low bits zero
// - Each group configures 32 channels, both directions
// - Clock enable drives expansion clock, else released
// - Soft reset clears map, ports, groups
`timescale 1ns/100ps
`default_nettype none
module host_global_cfg
  import link_cfg_pkg::*;
(
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  // APB slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // Expansion bus access request
  input wire logic ebus_req_in,
  input wire logic ebus_write_in,
  input wire logic [31:0] ebus_addr_in,
  input wire logic [31:0] ebus_wdata_in,
  output logic [31:0] ebus_rdata_out,
  output logic ebus_done_out,
  // Expansion bus pins
  input wire logic bus_grant_line_n_in,
  input wire logic hold_ack_line_in,
  input wire logic [31:0] ebus_ad_in,
  output logic bus_req_line_n_out,
  output logic hold_req_out,
  output logic address_valid_strobe_n_out,
  output logic addr_latch_strobe_n_out,
  output logic read_write_dir_out,
  output logic read_strobe_line_n_out,
  output logic write_strobe_line_n_out,
  output logic data_strobe_line_n_out,
  output logic [31:0] ebus_ad_out,
  output logic ebus_ad_oe_n_out,
  output logic expansion_bus_clock_out,
  output logic expansion_bus_clock_oe_n_out,
  // Host bus master address phase
  input wire logic master_req_in,
  input wire logic [31:0] master_addr_in,
  input wire logic [3:0] master_cmd_in,
  output logic [31:0] master_ad_out,
  output logic [3:0] master_cbe_out,
  output logic master_addr_phase_out,
  output logic master_addr_done_out,
  // Host bus target decode
  input wire logic target_frame_in,
  input wire logic [3:0] target_cmd_in,
  output logic target_claim_out,
  // Interrupt sources and open-drain pins
  input wire logic irq_a_req_in,
  input wire logic irq_b_req_in,
  output logic irq_a_out,
  output logic irq_a_oe_n_out,
  output logic irq_b_out,
  output logic irq_b_oe_n_out,
  // Port to group mapping and descriptor pointer lookup
  output logic [3*NUM_GROUPS-1:0] port_of_group_out,
  output logic [NUM_GROUPS-1:0] group_live_out,
  input wire logic [2:0] desc_group_in,
  input wire logic [4:0] desc_chan_in,
  input wire logic desc_dir_in,
  output logic [31:0] desc_addr_out
);
  typedef struct packed {
    logic [31:0] cfg;
    logic [31:0] dual_base;
    logic [7:0] port_en;
    logic [7:0] grp_act;
    logic [NUM_GROUPS-1:0][20:0] group_struct_base;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    ebus_state_t est;
    logic ewrite;
    logic [31:0] eaddr;
    logic [31:0] ewdata;
    logic [31:0] erdata;
    logic edone;
    logic breq_n;
    logic hreq;
    logic as_n;
    logic ale_n;
    logic rw;
    logic rd_n;
    logic wr_n;
    logic ds_n;
    logic [31:0] ead;
    logic ead_oe_n;
    logic expansion_bus_clock;
    logic expansion_bus_clock_oe_n;
    master_state_t mst;
    logic [3:0] mcmd;
    logic [31:0] mad;
    logic [3:0] mcbe;
    logic mphase;
    logic mdone;
    logic claim;
    logic irqa_oe_n;
    logic irqb_oe_n;
    logic [3*NUM_GROUPS-1:0] pmap;
    logic [NUM_GROUPS-1:0] live;
    logic [31:0] desc;
  } state_t;

  state_t s_q;
  state_t s_d;
  logic tick;
  logic t_load;
  logic [2:0] t_count;
  logic [2:0] t_rem;
  logic style_b;
  logic granted;
  logic [2:0] wr_idx;

  stretch_timer u_stretch_timer (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .load_in(t_load),
    .count_in(t_count),
    .tick_in(tick),
    .remaining_out(t_rem)
  );

  // Port serving a given group under the current map
  function automatic logic [2:0] port_for(input logic [1:0] map, input logic [2:0] g);
    logic [2:0] p;
    p = g;
    unique case (map)
      MAP_PAIRS: p = {1'b0, g[2:1]};
      MAP_QUADS: p = {2'b00, g[2]};
      // One to one, reserved code too
      default: p = g;
    endcase
    return p;
  endfunction : port_for

  function automatic logic [31:0] read_mux(input state_t s, input logic [11:0] a);
    logic [31:0] r;
    r = 32'h00000000;
    if (a == OFF_GLOBAL_CFG) begin
      r = s.cfg;
    end else if (a == OFF_DUAL_BASE) begin
      r = s.dual_base;
    end else if (a == OFF_CONTROL) begin
      r[POS_PORT_EN +: 8] = s.port_en;
      r[POS_GROUP_ACT +: 8] = s.grp_act;
    end else if (a == OFF_STATUS) begin
      r[4:0] = s.est;
      r[10:8] = s.mst;
      r[16] = s.dual_base != 32'h00000000;
    end else begin
      // Low eleven bits always read zero
      r = {s.group_struct_base[a[4:2]], 11'h000};
    end
    return r;
  endfunction : read_mux

  // Expansion clock runs at half the system rate; tick marks each period
  assign tick = s_q.expansion_bus_clock;
  assign style_b = s_q.cfg[POS_STYLE];
  assign wr_idx = paddr_in[4:2];
  // Grant sense follows the bus style
  assign granted = style_b ? hold_ack_line_in : !bus_grant_line_n_in;

  always_comb begin
    logic hit;
    logic group_struct_base_hit;
    logic [NUM_GROUPS-1:0] live_n;
    hit = 1'b0;
    group_struct_base_hit = 1'b0;
    live_n = '0;
    s_d = s_q;
    t_load = 1'b0;
    t_count = 3'h0;
    s_d.edone = 1'b0;
    s_d.mdone = 1'b0;

    // APB: one wait state, write lands on the edge pready is sampled
    group_struct_base_hit = paddr_in[11:5] == OFF_GROUP_BASE0[11:5] && paddr_in[1:0] == 2'h0;
    hit = paddr_in == OFF_GLOBAL_CFG || paddr_in == OFF_DUAL_BASE ||
          paddr_in == OFF_CONTROL || paddr_in == OFF_STATUS || group_struct_base_hit;
    s_d.pready = 1'b0;
    s_d.pslverr = 1'b0;
    if (psel_in && penable_in && !s_q.pready) begin
      s_d.pready = 1'b1;
      s_d.pslverr = !hit;
      s_d.prdata = (hit && !pwrite_in) ? read_mux(s_q, paddr_in) : 32'h00000000;
    end
    if (psel_in && penable_in && s_q.pready && pwrite_in && hit) begin
      if (paddr_in == OFF_GLOBAL_CFG) begin
        s_d.cfg = pwdata_in & GLOBAL_CFG_WMASK;
      end else if (paddr_in == OFF_DUAL_BASE) begin
        // Zero written here restores single cycles
        s_d.dual_base = pwdata_in;
      end else if (paddr_in == OFF_CONTROL) begin
        s_d.port_en = pwdata_in[POS_PORT_EN +: 8];
        s_d.grp_act = pwdata_in[POS_GROUP_ACT +: 8];
        // Soft reset clears map and ports
        if (pwdata_in[POS_SOFT_RESET]) begin
          s_d.cfg = GLOBAL_CFG_RESET;
          s_d.port_en = 8'h00;
          s_d.grp_act = 8'h00;
        end
      end else if (group_struct_base_hit) begin
        // Only the upper 21 bits are stored
        s_d.group_struct_base[wr_idx] = pwdata_in[31:GROUP_BASE_LSB];
      end
    end

    s_d.expansion_bus_clock = !s_q.expansion_bus_clock;
    s_d.expansion_bus_clock_oe_n = !s_q.cfg[POS_EXPANSION_BUS_CLOCK_EN];

    // Expansion bus sequencer
    unique case (s_q.est)
      EB_IDLE: begin
        if (ebus_req_in) begin
          s_d.est = EB_ARB;
          s_d.ewrite = ebus_write_in;
          s_d.eaddr = ebus_addr_in;
          s_d.ewdata = ebus_wdata_in;
        end
      end
      EB_ARB: begin
        if (granted && tick) begin
          s_d.est = EB_ADDR;
          t_load = 1'b1;
          t_count = {1'b0, s_q.cfg[POS_ADDR_STRETCH +: 2]};
        end
      end
      EB_ADDR: begin
        if (tick && t_rem == 3'h0) begin
          s_d.est = EB_DATA;
          t_load = 1'b1;
          t_count = s_q.cfg[POS_DATA_STRETCH +: 3];
        end
      end
      EB_DATA: begin
        if (tick && t_rem == 3'h0) begin
          s_d.est = EB_REL;
          s_d.erdata = s_q.ewrite ? s_q.erdata : ebus_ad_in;
          s_d.edone = 1'b1;
        end
      end
      EB_REL: begin
        s_d.est = EB_IDLE;
      end
      default: begin
        s_d.est = EB_IDLE;
      end
    endcase

    s_d.breq_n = !(!style_b && s_d.est != EB_IDLE && s_d.est != EB_REL);
    s_d.hreq = style_b && s_d.est != EB_IDLE && s_d.est != EB_REL;
    s_d.ead_oe_n = 1'b1;
    s_d.ead = 32'h00000000;
    if (s_d.est == EB_ADDR) begin
      s_d.ead = s_q.eaddr;
      s_d.ead_oe_n = 1'b0;
    end else if (s_d.est == EB_DATA && s_q.ewrite) begin
      s_d.ead = s_q.ewdata;
      s_d.ead_oe_n = 1'b0;
    end
    s_d.as_n = !(!style_b && s_q.est == EB_ADDR && t_rem == 3'h0);
    s_d.ale_n = !(style_b && s_q.est == EB_ADDR && t_rem == 3'h0);
    // Data strobes in last data period
    s_d.rw = !s_q.ewrite;
    s_d.ds_n = !(!style_b && s_q.est == EB_DATA && t_rem == 3'h0);
    s_d.rd_n = !(s_q.est == EB_DATA && t_rem == 3'h0 && !s_q.ewrite);
    s_d.wr_n = !(style_b && s_q.est == EB_DATA && t_rem == 3'h0 && s_q.ewrite);

    // Host master address phase
    s_d.mphase = 1'b0;
    unique case (s_q.mst)
      PM_IDLE: begin
        if (master_req_in) begin
          s_d.mcmd = master_cmd_in;
          s_d.mphase = 1'b1;
          if (s_q.dual_base != 32'h00000000) begin
            s_d.mst = PM_LOW;
            s_d.mad = master_addr_in;
            s_d.mcbe = CMD_DUAL_ADDR;
          end else begin
            s_d.mst = PM_CMD;
            s_d.mad = master_addr_in;
            s_d.mcbe = master_cmd_in;
          end
        end
      end
      PM_LOW: begin
        s_d.mst = PM_CMD;
        s_d.mphase = 1'b1;
        s_d.mad = s_q.dual_base;
        s_d.mcbe = s_q.mcmd;
      end
      PM_CMD: begin
        s_d.mst = PM_IDLE;
        s_d.mdone = 1'b1;
      end
      default: begin
        s_d.mst = PM_IDLE;
      end
    endcase

    s_d.claim = target_frame_in && target_cmd_in != CMD_DUAL_ADDR;

    s_d.irqa_oe_n = !(irq_a_req_in && !s_q.cfg[POS_IRQ_A_MASK]);
    s_d.irqb_oe_n = !(irq_b_req_in && !s_q.cfg[POS_IRQ_B_MASK]);

    for (int g = 0; g < NUM_GROUPS; g++) begin
      s_d.pmap[3*g +: 3] = port_for(s_q.cfg[POS_PORT_MAP +: 2], 3'(g));
      live_n[g] = s_q.grp_act[g] && s_q.port_en[port_for(s_q.cfg[POS_PORT_MAP +: 2], 3'(g))];
    end
    s_d.live = live_n;

    // Per channel, per direction head pointer slot
    s_d.desc = {s_q.group_struct_base[desc_group_in], 3'h0, desc_dir_in, desc_chan_in, 2'h0};
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      s_q <= '0;
      s_q.cfg <= GLOBAL_CFG_RESET;
      s_q.dual_base <= DUAL_BASE_RESET;
      s_q.group_struct_base <= {NUM_GROUPS{GROUP_BASE_RESET}};
      s_q.est <= EB_IDLE;
      s_q.mst <= PM_IDLE;
      s_q.breq_n <= 1'b1;
      s_q.as_n <= 1'b1;
      s_q.ale_n <= 1'b1;
      s_q.rw <= 1'b1;
      s_q.rd_n <= 1'b1;
      s_q.wr_n <= 1'b1;
      s_q.ds_n <= 1'b1;
      s_q.ead_oe_n <= 1'b1;
      s_q.expansion_bus_clock_oe_n <= 1'b1;
      s_q.irqa_oe_n <= 1'b1;
      s_q.irqb_oe_n <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata_out = s_q.prdata;
  assign pready_out = s_q.pready;
  assign pslverr_out = s_q.pslverr;
  assign ebus_rdata_out = s_q.erdata;
  assign ebus_done_out = s_q.edone;
  assign bus_req_line_n_out = s_q.breq_n;
  assign hold_req_out = s_q.hreq;
  assign address_valid_strobe_n_out = s_q.as_n;
  assign addr_latch_strobe_n_out = s_q.ale_n;
  assign read_write_dir_out = s_q.rw;
  assign read_strobe_line_n_out = s_q.rd_n;
  assign write_strobe_line_n_out = s_q.wr_n;
  assign data_strobe_line_n_out = s_q.ds_n;
  assign ebus_ad_out = s_q.ead;
  assign ebus_ad_oe_n_out = s_q.ead_oe_n;
  assign expansion_bus_clock_out = s_q.expansion_bus_clock;
  assign expansion_bus_clock_oe_n_out = s_q.expansion_bus_clock_oe_n;
  assign master_ad_out = s_q.mad;
  assign master_cbe_out = s_q.mcbe;
  assign master_addr_phase_out = s_q.mphase;
  assign master_addr_done_out = s_q.mdone;
  assign target_claim_out = s_q.claim;
  // Open drain: drive low only, release otherwise
  assign irq_a_out = 1'b0;
  assign irq_a_oe_n_out = s_q.irqa_oe_n;
  assign irq_b_out = 1'b0;
  assign irq_b_oe_n_out = s_q.irqb_oe_n;
  assign port_of_group_out = s_q.pmap;
  assign group_live_out = s_q.live;
  assign desc_addr_out = s_q.desc;
endmodule : host_global_cfg
`default_nettype wire

// file: hw/link_cfg_pkg.sv
/*
  Shared constants for the host global and group base configuration block:
  register offsets, field positions, reset values, bus codes and states.
  Assumes a 32-bit APB register bus and a 250 MHz system clock.
*/
package link_cfg_pkg;
  // Register byte offsets
  localparam logic [11:0] OFF_GLOBAL_CFG = 12'h000;
  localparam logic [11:0] OFF_DUAL_BASE = 12'h004;
  localparam logic [11:0] OFF_CONTROL = 12'h008;
  localparam logic [11:0] OFF_STATUS = 12'h00C;
  localparam logic [11:0] OFF_GROUP_BASE0 = 12'h020;
  localparam int NUM_GROUPS = 8;
  localparam int CHANNELS_PER_GROUP = 32;
  // Global configuration fields
  localparam int POS_PORT_MAP = 0;
  localparam int POS_IRQ_B_MASK = 2;
  localparam int POS_IRQ_A_MASK = 3;
  localparam int POS_DATA_STRETCH = 4;
  localparam int POS_ADDR_STRETCH = 8;
  localparam int POS_STYLE = 10;
  localparam int POS_EXPANSION_BUS_CLOCK_EN = 11;
  localparam logic [31:0] GLOBAL_CFG_WMASK = 32'h00007F7F;
  localparam logic [31:0] GLOBAL_CFG_RESET = 32'h00000000;
  localparam logic [31:0] DUAL_BASE_RESET = 32'h00000000;
  localparam logic [20:0] GROUP_BASE_RESET = 21'h000000;
  localparam int GROUP_BASE_LSB = 11;
  // Control register fields
  localparam int POS_SOFT_RESET = 0;
  localparam int POS_PORT_EN = 8;
  localparam int POS_GROUP_ACT = 16;
  // Port map encodings
  localparam logic [1:0] MAP_ONE_TO_ONE = 2'h0;
  localparam logic [1:0] MAP_PAIRS = 2'h1;
  localparam logic [1:0] MAP_QUADS = 2'h2;
  // Host bus command codes
  localparam logic [3:0] CMD_DUAL_ADDR = 4'hD;
  // Expansion bus states
  typedef enum logic [4:0] {
    EB_IDLE = 5'b00001,
    EB_ARB = 5'b00010,
    EB_ADDR = 5'b00100,
    EB_DATA = 5'b01000,
    EB_REL = 5'b10000
  } ebus_state_t;
  // Host master address phase states
  typedef enum logic [2:0] {
    PM_IDLE = 3'b001,
    PM_LOW = 3'b010,
    PM_CMD = 3'b100
  } master_state_t;
endpackage : link_cfg_pkg

// file: hw/stretch_timer.sv
/*
  Phase stretch counter: loads a count and steps down once per expansion
  clock period. Assumes the load and tick strobes come from the same clock.
*/
`timescale 1ns/100ps
`default_nettype none
module stretch_timer (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  // Control
  input wire logic load_in,
  input wire logic [2:0] count_in,
  input wire logic tick_in,
  // Remaining periods
  output logic [2:0] remaining_out
);
  typedef struct packed {
    logic [2:0] cnt;
  } timer_t;
  timer_t s_q;
  timer_t s_d;

  always_comb begin
    s_d = s_q;
    // Load wins so a phase never starts with a stale count
    if (load_in) begin
      s_d.cnt = count_in;
    end else if (tick_in && s_q.cnt != 3'h0) begin
      s_d.cnt = s_q.cnt - 3'h1;
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign remaining_out = s_q.cnt;
endmodule : stretch_timer
`default_nettype wire

// file: bench/host_global_cfg_sva.sv
/* Port checker for host_global_cfg, attached by bind.
   Assumes one clock and a synchronous active-high reset. */
`timescale 1ns/100ps
`default_nettype none
module host_global_cfg_sva
  import link_cfg_pkg::*;
(
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  // Host bus side
  input wire logic target_frame_in,
  input wire logic [3:0] target_cmd_in,
  input wire logic target_claim_out,
  input wire logic [31:0] master_addr_in,
  input wire logic [3:0] master_cmd_in,
  input wire logic [31:0] master_ad_out,
  input wire logic [3:0] master_cbe_out,
  input wire logic master_addr_phase_out,
  input wire logic master_addr_done_out,
  // Interrupt, lookup, expansion pins
  input wire logic irq_a_req_in,
  input wire logic irq_a_out,
  input wire logic irq_a_oe_n_out,
  input wire logic desc_dir_in,
  input wire logic [4:0] desc_chan_in,
  input wire logic [31:0] desc_addr_out,
  input wire logic expansion_bus_clock_out,
  input wire logic expansion_bus_clock_oe_n_out,
  input wire logic address_valid_strobe_n_out,
  input wire logic addr_latch_strobe_n_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (rst_in);
  property p_claim;
    target_frame_in && target_cmd_in != CMD_DUAL_ADDR |=> target_claim_out;
  endproperty
  a_claim: assert property (p_claim) else $error("target access not claimed");
  property p_noclaim;
    target_frame_in && target_cmd_in == CMD_DUAL_ADDR |=> !target_claim_out;
  endproperty
  a_noclaim: assert property (p_noclaim) else $error("dual cycle claimed");
  property p_phase_len;
    master_addr_phase_out [*2] |=> !master_addr_phase_out;
  endproperty
  a_phase_len: assert property (p_phase_len) else $error("address phase too long");
  property p_phase_done;
    $fell(master_addr_phase_out) |-> master_addr_done_out;
  endproperty
  a_phase_done: assert property (p_phase_done) else $error("no done after phase");
  property p_dual_next;
    master_addr_phase_out && master_cbe_out == CMD_DUAL_ADDR
      |=> master_addr_phase_out && master_cbe_out == $past(master_cmd_in, 2);
  endproperty
  a_dual_next: assert property (p_dual_next) else $error("bad second period");
  property p_first_ad;
    $rose(master_addr_phase_out) |-> master_ad_out == $past(master_addr_in);
  endproperty
  a_first_ad: assert property (p_first_ad) else $error("bad first address word");
  property p_irq_a;
    !irq_a_oe_n_out |-> $past(irq_a_req_in) && !irq_a_out;
  endproperty
  a_irq_a: assert property (p_irq_a) else $error("line A pulled without request");
  property p_desc;
    !$past(rst_in) |-> desc_addr_out[10:0] ==
      {3'h0, $past(desc_dir_in), $past(desc_chan_in), 2'h0};
  endproperty
  a_desc: assert property (p_desc) else $error("descriptor slot wrong");
  property p_expansion_bus_clock;
    !expansion_bus_clock_oe_n_out && !$past(expansion_bus_clock_oe_n_out)
      |-> expansion_bus_clock_out != $past(expansion_bus_clock_out);
  endproperty
  a_expansion_bus_clock: assert property (p_expansion_bus_clock) else $error("expansion clock stuck");
  property p_style_excl;
    !(!address_valid_strobe_n_out && !addr_latch_strobe_n_out);
  endproperty
  a_style_excl: assert property (p_style_excl) else $error("both strobes low");
endmodule : host_global_cfg_sva
bind host_global_cfg host_global_cfg_sva chk_u (.*);
`default_nettype wire

// file: bench/ebus_partner.sv
/* Expansion bus processor model: grants after a lag, returns read data.
   Assumes the bench tells it the bus style in use. */
`timescale 1ns/100ps
`default_nettype none
module ebus_partner #(
  parameter logic [31:0] RD_WORD = 32'hC3C30FF0
) (
  // Clock and setup
  input wire logic clock_in,
  input wire logic style_in,
  input wire logic [1:0] lag_in,
  // Pins from the block
  input wire logic bus_req_line_n_in,
  input wire logic hold_req_in,
  input wire logic read_strobe_line_n_in,
  // Pins to the block
  output logic bus_grant_line_n_out,
  output logic hold_ack_line_out,
  output logic [31:0] ebus_ad_out
);
  logic [2:0] wait_q = 3'h0;
  logic rd_q = 1'h0;
  logic [31:0] last_q = 32'h0;
  logic req;
  logic grant;
  assign req = style_in ? hold_req_in : !bus_req_line_n_in;
  assign grant = req && wait_q > {1'h0, lag_in};
  assign bus_grant_line_n_out = !(grant && !style_in);
  assign hold_ack_line_out = grant && style_in;
  // Released bus toggles so stale data never matches
  assign ebus_ad_out = (!read_strobe_line_n_in || rd_q) ? RD_WORD : ~last_q;
  always_ff @(posedge clock_in) begin
    wait_q <= !req ? 3'h0 : (wait_q == 3'h7 ? wait_q : wait_q + 3'h1);
    rd_q <= !read_strobe_line_n_in;
    last_q <= ebus_ad_out;
  end
endmodule : ebus_partner
`default_nettype wire

// file: bench/host_global_cfg_tb.sv
/* Self-checking bench for host_global_cfg over APB and its pins.
   Assumes the ebus_partner model and the bound checker. */
`timescale 1ns/100ps
`default_nettype none
module host_global_cfg_tb;
  import link_cfg_pkg::*;
  localparam logic [31:0] RD_WORD = 32'h3C5AA5C3;
  logic clock_in = 0, rst_in = 1, psel_in = 0, penable_in = 0, pwrite_in = 0;
  logic [11:0] paddr_in = 0;
  logic [31:0] pwdata_in = 0, ebus_addr_in = 0, ebus_wdata_in = 0, master_addr_in = 0;
  logic ebus_req_in = 0, ebus_write_in = 0, master_req_in = 0, target_frame_in = 0;
  logic irq_a_req_in = 0, irq_b_req_in = 0, desc_dir_in = 0, sty = 0;
  logic [3:0] master_cmd_in = 0, target_cmd_in = 0;
  logic [2:0] desc_group_in = 0;
  logic [4:0] desc_chan_in = 0;
  logic [1:0] lag = 0;
  logic [31:0] prdata_out, ebus_rdata_out, ebus_ad_out, ebus_ad_in, master_ad_out, desc_addr_out;
  logic pready_out, pslverr_out, ebus_done_out, bus_grant_line_n_in, hold_ack_line_in;
  logic bus_req_line_n_out, hold_req_out, address_valid_strobe_n_out, addr_latch_strobe_n_out;
  logic read_write_dir_out, read_strobe_line_n_out, write_strobe_line_n_out;
  logic data_strobe_line_n_out, ebus_ad_oe_n_out, expansion_bus_clock_out;
  logic expansion_bus_clock_oe_n_out, master_addr_phase_out, master_addr_done_out;
  logic target_claim_out, irq_a_out, irq_a_oe_n_out, irq_b_out, irq_b_oe_n_out;
  logic [3:0] master_cbe_out;
  logic [23:0] port_of_group_out;
  logic [7:0] group_live_out;
  int fails = 0;
  int n_checks = 0;
  host_global_cfg dut_u (.*);
  ebus_partner #(.RD_WORD(RD_WORD)) pm_u (.clock_in, .style_in(sty), .lag_in(lag),
    .bus_req_line_n_in(bus_req_line_n_out), .hold_req_in(hold_req_out),
    .read_strobe_line_n_in(read_strobe_line_n_out), .bus_grant_line_n_out(bus_grant_line_n_in),
    .hold_ack_line_out(hold_ack_line_in), .ebus_ad_out(ebus_ad_in));
  always #2 clock_in = ~clock_in;
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    n_checks++;
    if (s !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // Pready sampled at the rising edge; request held until then
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge clock_in);
    psel_in <= 1;
    penable_in <= 0;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clock_in);
    penable_in <= 1;
    do begin
      @(posedge clock_in);
    end while (pready_out !== 1'h1);
    r = prdata_out;
    e = pslverr_out;
    psel_in <= 0;
    penable_in <= 0;
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1, a, d, r, e);
    repeat (2) @(negedge clock_in);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] x, input string n);
    logic [31:0] r;
    logic e;
    apb(0, a, 32'h0, r, e);
    chk(n, x, r);
  endtask : rd
  task automatic t_regs;
    logic [31:0] r;
    logic e;
    rd(OFF_GLOBAL_CFG, GLOBAL_CFG_RESET, "cfg reset");
    rd(OFF_DUAL_BASE, DUAL_BASE_RESET, "dual reset");
    rd(OFF_GROUP_BASE0 + 12'h01C, 32'h0, "group7 reset");
    wr(OFF_GLOBAL_CFG, 32'hFFFFFFFF);
    rd(OFF_GLOBAL_CFG, GLOBAL_CFG_WMASK, "cfg mask");
    wr(OFF_GROUP_BASE0 + 12'h00C, 32'h12345FFF);
    rd(OFF_GROUP_BASE0 + 12'h00C, 32'h12345800, "group3 ptr");
    apb(0, 12'h100, 32'h0, r, e);
    chk("unmapped err", 32'h1, e);
  endtask : t_regs
  task automatic t_map;
    logic [23:0] x;
    for (int m = 0; m < 3; m++) begin
      wr(OFF_GLOBAL_CFG, m);
      for (int g = 0; g < 8; g++) x[3*g+:3] = g >> m;
      chk("port map", x, port_of_group_out);
    end
    wr(OFF_CONTROL, 32'h00FFFF00);
    chk("groups live", 32'hFF, group_live_out);
    wr(OFF_CONTROL, 32'h1);
    rd(OFF_GLOBAL_CFG, 32'h0, "cfg soft reset");
    chk("groups dead", 32'h0, group_live_out);
  endtask : t_map
  task automatic t_master(input logic [31:0] ub);
    wr(OFF_DUAL_BASE, ub);
    @(posedge clock_in);
    master_req_in <= 1;
    master_addr_in <= 32'h0BADF00C;
    master_cmd_in <= 4'h7;
    @(posedge clock_in);
    master_req_in <= 0;
    @(negedge clock_in);
    chk("first ad", 32'h0BADF00C, master_ad_out);
    chk("first cbe", ub != 0 ? CMD_DUAL_ADDR : 4'h7, master_cbe_out);
    if (ub != 0) begin
      @(negedge clock_in);
      chk("upper ad", ub, master_ad_out);
      chk("second cbe", 32'h7, master_cbe_out);
    end
    @(negedge clock_in);
    chk("addr done", 32'h1, master_addr_done_out);
  endtask : t_master
  task automatic t_misc;
    for (int i = 0; i < 3; i++) begin
      @(posedge clock_in);
      target_frame_in <= 1;
      target_cmd_in <= i == 1 ? CMD_DUAL_ADDR : 4'h6;
      @(posedge clock_in);
      target_frame_in <= 0;
      @(negedge clock_in);
      chk("claim", i != 1, target_claim_out);
    end
    @(posedge clock_in);
    irq_a_req_in <= 1;
    irq_b_req_in <= 1;
    wr(OFF_GLOBAL_CFG, 32'h8);
    chk("irq oe", 32'h2, {irq_a_oe_n_out, irq_b_oe_n_out});
    wr(OFF_GLOBAL_CFG, 32'h4);
    chk("irq oe", 32'h1, {irq_a_oe_n_out, irq_b_oe_n_out});
    @(posedge clock_in);
    desc_group_in <= 3'h3;
    desc_chan_in <= 5'h5;
    desc_dir_in <= 1;
    repeat (2) @(negedge clock_in);
    chk("desc addr", 32'h12345894, desc_addr_out);
  endtask : t_misc
  task automatic t_ebus(input logic s, input logic [1:0] a, input logic [2:0] d);
    int ca = 0, cd = 0, ok = 0, bad = 0, k = 0, sd = 0;
    sty = s;
    wr(OFF_GLOBAL_CFG, {20'h0, 1'h1, s, a, 1'h0, d, 4'h0});
    for (int w = 1; w >= 0; w--) begin
      k = 0;
      @(posedge clock_in);
      ebus_req_in <= 1;
      ebus_write_in <= w;
      ebus_addr_in <= 32'hA5000010;
      ebus_wdata_in <= 32'h5A00F00D;
      @(posedge clock_in);
      ebus_req_in <= 0;
      do begin
        @(negedge clock_in);
        k++;
        if (w && !ebus_ad_oe_n_out && ebus_ad_out == 32'hA5000010) ca++;
        if (w && !ebus_ad_oe_n_out && ebus_ad_out == 32'h5A00F00D) cd++;
        if (!(s ? addr_latch_strobe_n_out : address_valid_strobe_n_out)) ok++;
        if (!(s ? address_valid_strobe_n_out : addr_latch_strobe_n_out)) bad++;
        if (s ? !bus_req_line_n_out : hold_req_out) bad++;
        if (!(s ? data_strobe_line_n_out : write_strobe_line_n_out)) bad++;
        if (w && !ebus_ad_oe_n_out && ebus_ad_out == 32'h5A00F00D && read_write_dir_out) bad++;
        if (!(s ? (w ? write_strobe_line_n_out : read_strobe_line_n_out)
                : data_strobe_line_n_out)) sd++;
      end while (ebus_done_out !== 1'h1 && k < 400);
      repeat (2) @(posedge clock_in);
    end
    chk("addr cycles", 2 * (a + 1), ca);
    chk("data cycles", 2 * (d + 1), cd);
    chk("style strobe", 32'h1, ok > 0 && bad == 0);
    chk("data strobes", 32'h4, sd);
    chk("read data", RD_WORD, ebus_rdata_out);
    chk("expansion_bus_clock driven", 32'h0, expansion_bus_clock_oe_n_out);
  endtask : t_ebus
  task automatic complete_run;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : complete_run
  initial begin
    #100000;
    fails++;
    complete_run();
  end
  initial begin
    repeat (3) @(posedge clock_in);
    rst_in <= 0;
    t_regs();
    t_map();
    t_master(32'h0);
    t_master(32'h000000A7);
    t_master(32'h0);
    t_misc();
    lag = 2'h0;
    t_ebus(0, 2'h3, 3'h0);
    lag = 2'h3;
    t_ebus(1, 2'h0, 3'h7);
    t_ebus(0, 2'h1, 3'h2);
    complete_run();
  end
endmodule : host_global_cfg_tb
`default_nettype wire
